// file: host_mcu_model.sv
// Microcontroller side of the register strobes
module host_mcu_model
  import irq_enable_pkg::*;
(
  // Clock
  input  wire logic                  sys_clk,
  // Strobes
  output logic                       reg_wr_en,
  output logic      [BYTE_LANES-1:0] reg_wr_be,
  output logic      [REG_WIDTH-1:0]  reg_wr_data,
  output logic                       reg_rd_en,
  // Answer
  input  wire logic [REG_WIDTH-1:0]  reg_rd_data,
  input  wire logic                  reg_rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_wr_en = 1'b0;
    reg_wr_be = 4'h0;
    reg_wr_data = 32'h0;
    reg_rd_en = 1'b0;
  end
  ////////////////////////////////////////
  // Data is inverted once released so a stale bus never looks valid
  task automatic wr(input logic [3:0] be, input logic [31:0] d);
    @(negedge sys_clk);
    reg_wr_en = 1'b1;
    reg_wr_be = be;
    reg_wr_data = d;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_wr_be = 4'h0;
    reg_wr_data = ~d;
  endtask : wr
  // Optional full write in the same cycle as the read
  task automatic rd(input logic w, input logic [31:0] wd, output logic v,
                    output logic [31:0] d);
    @(negedge sys_clk);
    reg_rd_en = 1'b1;
    reg_wr_en = w;
    reg_wr_be = {4{w}};
    reg_wr_data = wd;
    // The answer stands only for the cycle after the taking edge: take it here
    @(negedge sys_clk);
    v = reg_rd_valid;
    d = reg_rd_data;
    reg_rd_en = 1'b0;
    reg_wr_en = 1'b0;
    reg_wr_data = ~wd;
  endtask : rd
endmodule : host_mcu_model

// file: irq_enable_mask.sv
// Interrupt source enable mask register with its interrupt gating
module irq_enable_mask
  import irq_enable_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Register access from the microcontroller interface
  input  wire logic                  reg_wr_en,
  input  wire logic [BYTE_LANES-1:0] reg_wr_be,
  input  wire logic [REG_WIDTH-1:0]  reg_wr_data,
  input  wire logic                  reg_rd_en,
  output logic      [REG_WIDTH-1:0]  reg_rd_data,
  output logic                       reg_rd_valid,
  // Event flags from the interrupt status logic
  input  wire logic [EP_LAST:EP_FIRST] ep_rx_event,
  input  wire logic [EP_LAST:EP_FIRST] ep_tx_event,
  input  wire logic                  ctrl_in_event,
  input  wire logic                  ctrl_out_event,
  input  wire logic                  setup_packet_event,
  input  wire logic                  bus_power_sense_event,
  input  wire logic                  dma_reason_change_event,
  input  wire logic                  speed_status_change_event,
  input  wire logic                  resume_event,
  input  wire logic                  suspend_event,
  input  wire logic                  pseudo_frame_start_event,
  input  wire logic                  frame_start_event,
  input  wire logic                  bus_reset_event,
  // Interrupt result
  output logic                       irq,
  output logic      [REG_WIDTH-1:0]  irq_pending,
  // Individual enables for the status logic
  output logic                       ep7_tx_irq_en,
  output logic                       ep7_rx_irq_en,
  output logic                       ep6_tx_irq_en,
  output logic                       ep6_rx_irq_en,
  output logic                       ep5_tx_irq_en,
  output logic                       ep5_rx_irq_en,
  output logic                       ep4_tx_irq_en,
  output logic                       ep4_rx_irq_en,
  output logic                       ep3_tx_irq_en,
  output logic                       ep3_rx_irq_en,
  output logic                       ep2_tx_irq_en,
  output logic                       ep2_rx_irq_en,
  output logic                       ep1_tx_irq_en,
  output logic                       ep1_rx_irq_en,
  output logic                       ctrl_in_irq_en,
  output logic                       ctrl_out_irq_en,
  output logic                       setup_packet_irq_en,
  output logic                       bus_power_sense_irq_en,
  output logic                       dma_reason_change_irq_en,
  output logic                       speed_status_change_irq_en,
  output logic                       resume_irq_en,
  output logic                       suspend_irq_en,
  output logic                       pseudo_frame_start_irq_en,
  output logic                       frame_start_irq_en,
  output logic                       bus_reset_irq_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lane b covers bits 8b+7 down to 8b
  // Byte-lane merge; reserved bits never take a write so they stay 0
  function automatic logic [REG_WIDTH-1:0] merge_write(
    input logic [REG_WIDTH-1:0]  old_value,
    input logic [REG_WIDTH-1:0]  new_value,
    input logic [BYTE_LANES-1:0] lanes
  );
    logic [REG_WIDTH-1:0] lane_mask;
    lane_mask = '0;
    for (int b = 0; b < BYTE_LANES; b++) begin
      lane_mask[b*8 +: 8] = {8{lanes[b]}};
    end
    lane_mask = lane_mask & ENABLE_WRITABLE;
    return (old_value & ~lane_mask) | (new_value & lane_mask);
  endfunction : merge_write

  ////////////////////////////////////////////////////////////////////////////
  // Event vector in register bit order

  // Flags come from same-clock status logic, so no synchroniser is placed here.
  // Reserved positions stay 0 so they can never raise the line.
  logic [REG_WIDTH-1:0] event_vec;

  always_comb begin
    event_vec = '0;
    for (int ep = EP_FIRST; ep <= EP_LAST; ep++) begin
      event_vec[ep_rx_bit(ep)] = ep_rx_event[ep];
      event_vec[ep_tx_bit(ep)] = ep_tx_event[ep];
    end
    event_vec[BIT_CTRL_IN]             = ctrl_in_event;
    event_vec[BIT_CTRL_OUT]            = ctrl_out_event;
    event_vec[BIT_SETUP_PACKET]        = setup_packet_event;
    event_vec[BIT_BUS_POWER_SENSE]     = bus_power_sense_event;
    event_vec[BIT_DMA_REASON_CHANGE]   = dma_reason_change_event;
    event_vec[BIT_SPEED_STATUS_CHANGE] = speed_status_change_event;
    event_vec[BIT_RESUME]              = resume_event;
    event_vec[BIT_SUSPEND]             = suspend_event;
    event_vec[BIT_PSEUDO_FRAME_START]  = pseudo_frame_start_event;
    event_vec[BIT_FRAME_START]         = frame_start_event;
    event_vec[BIT_BUS_RESET]           = bus_reset_event;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable register

  // Only rst_n clears the enables; a bus reset on the link leaves them alone,
  // so firmware need not re-arm every source after each bus reset
  logic [REG_WIDTH-1:0] enable_q;
  logic [REG_WIDTH-1:0] enable_d;

  always_comb begin
    enable_d = enable_q;
    if (reg_wr_en) begin
      enable_d = merge_write(enable_q, reg_wr_data, reg_wr_be);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= ENABLE_RESET_VALUE;
    end else begin
      enable_q <= enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe, value before any same-cycle write

  // Taking the value before a same-cycle write keeps a read-modify-write
  // from the host from seeing half of its own update
  logic [REG_WIDTH-1:0] rd_data_q;
  logic [REG_WIDTH-1:0] rd_data_d;
  logic                 rd_valid_q;
  logic                 rd_valid_d;

  always_comb begin
    rd_data_d  = rd_data_q;
    rd_valid_d = reg_rd_en;
    if (reg_rd_en) begin
      rd_data_d = enable_q & ENABLE_WRITABLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q  <= ENABLE_RESET_VALUE;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign reg_rd_data  = rd_data_q;
  assign reg_rd_valid = rd_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Gating of sources onto the interrupt line

  // The line lags the flags by one cycle; it comes from a flop so that no
  // combinational path runs from a status flag to the host's interrupt pin
  irq_source_gate u_gate (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .event_flags (event_vec),
    .enable_mask (enable_q),
    .pending_q   (irq_pending),
    .irq_q       (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Individual enable outputs, taken straight from the register flops

  // Data endpoints 7 down to 1
  assign ep7_tx_irq_en              = enable_q[ep_tx_bit(7)];
  assign ep7_rx_irq_en              = enable_q[ep_rx_bit(7)];
  assign ep6_tx_irq_en              = enable_q[ep_tx_bit(6)];
  assign ep6_rx_irq_en              = enable_q[ep_rx_bit(6)];
  assign ep5_tx_irq_en              = enable_q[ep_tx_bit(5)];
  assign ep5_rx_irq_en              = enable_q[ep_rx_bit(5)];
  assign ep4_tx_irq_en              = enable_q[ep_tx_bit(4)];
  assign ep4_rx_irq_en              = enable_q[ep_rx_bit(4)];
  assign ep3_tx_irq_en              = enable_q[ep_tx_bit(3)];
  assign ep3_rx_irq_en              = enable_q[ep_rx_bit(3)];
  assign ep2_tx_irq_en              = enable_q[ep_tx_bit(2)];
  assign ep2_rx_irq_en              = enable_q[ep_rx_bit(2)];
  assign ep1_tx_irq_en              = enable_q[ep_tx_bit(1)];
  assign ep1_rx_irq_en              = enable_q[ep_rx_bit(1)];

  // Control endpoint 0
  assign ctrl_in_irq_en             = enable_q[BIT_CTRL_IN];
  assign ctrl_out_irq_en            = enable_q[BIT_CTRL_OUT];
  assign setup_packet_irq_en        = enable_q[BIT_SETUP_PACKET];

  // Bus and device events
  assign bus_power_sense_irq_en     = enable_q[BIT_BUS_POWER_SENSE];
  assign dma_reason_change_irq_en   = enable_q[BIT_DMA_REASON_CHANGE];
  assign speed_status_change_irq_en = enable_q[BIT_SPEED_STATUS_CHANGE];
  assign resume_irq_en              = enable_q[BIT_RESUME];
  assign suspend_irq_en             = enable_q[BIT_SUSPEND];
  assign pseudo_frame_start_irq_en  = enable_q[BIT_PSEUDO_FRAME_START];
  assign frame_start_irq_en         = enable_q[BIT_FRAME_START];
  assign bus_reset_irq_en           = enable_q[BIT_BUS_RESET];

endmodule : irq_enable_mask

// file: irq_enable_mask_asserts.sv
// Port checker for the interrupt source enable mask
module irq_enable_mask_asserts
  import irq_enable_pkg::*;
(
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  // Register strobes
  input wire logic                     reg_wr_en,
  input wire logic [BYTE_LANES-1:0]    reg_wr_be,
  input wire logic [REG_WIDTH-1:0]     reg_wr_data,
  input wire logic                     reg_rd_en,
  input wire logic [REG_WIDTH-1:0]     reg_rd_data,
  input wire logic                     reg_rd_valid,
  // Sources and results
  input wire logic                     bus_reset_event,
  input wire logic [EP_LAST:EP_FIRST]  ep_tx_event,
  input wire logic                     irq,
  input wire logic [REG_WIDTH-1:0]     irq_pending,
  input wire logic                     bus_reset_irq_en,
  input wire logic                     ep7_tx_irq_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  property p_rd_valid;
    reg_rd_en |=> reg_rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_rd_old;
    reg_rd_en |=> reg_rd_data[0] == $past(bus_reset_irq_en);
  endproperty
  a_rd_old: assert property (p_rd_old) else $error("read data wrong");
  property p_rsvd_rd;
    reg_rd_valid |-> (reg_rd_data & 32'hFC00_0200) == 32'h0;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bit read 1");
  property p_rsvd_pend;
    (irq_pending & 32'hFC00_0200) == 32'h0;
  endproperty
  a_rsvd_pend: assert property (p_rsvd_pend) else $error("reserved pending");
  property p_irq_or;
    irq == (|irq_pending);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of pending");
  property p_wr_b0;
    reg_wr_en && reg_wr_be[0] |=> bus_reset_irq_en == $past(reg_wr_data[0]);
  endproperty
  a_wr_b0: assert property (p_wr_b0) else $error("enable bit 0 not written");
  property p_hold25;
    !(reg_wr_en && reg_wr_be[3]) |=> $stable(ep7_tx_irq_en);
  endproperty
  a_hold25: assert property (p_hold25) else $error("enable bit 25 moved");
  property p_pend0;
    ##1 irq_pending[0] == $past(bus_reset_event && bus_reset_irq_en);
  endproperty
  a_pend0: assert property (p_pend0) else $error("bit 0 gating wrong");
  property p_pend25;
    ##1 irq_pending[25] == $past(ep_tx_event[7] && ep7_tx_irq_en);
  endproperty
  a_pend25: assert property (p_pend25) else $error("bit 25 gating wrong");
  c_irq: cover property (irq);
  c_rd: cover property (reg_rd_valid);
  c_part: cover property (reg_wr_en && reg_wr_be != 4'hF);
endmodule : irq_enable_mask_asserts

bind irq_enable_mask irq_enable_mask_asserts i_irq_enable_mask_asserts (
  .sys_clk, .rst_n, .reg_wr_en, .reg_wr_be, .reg_wr_data, .reg_rd_en, .reg_rd_data,
  .reg_rd_valid, .bus_reset_event, .ep_tx_event, .irq, .irq_pending,
  .bus_reset_irq_en, .ep7_tx_irq_en);

// file: irq_enable_pkg.sv
// Constants for the interrupt source enable mask
package irq_enable_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register geometry
  localparam int          REG_WIDTH   = 32;
  localparam int          BYTE_LANES  = 4;
  localparam int          EP_FIRST    = 1;
  localparam int          EP_LAST     = 7;

  // Value after hardware reset: every source masked
  localparam logic [31:0] ENABLE_RESET_VALUE = 32'h0000_0000;

  // Bits that hold storage; bit 9 and bits 31 to 26 are reserved and read 0
  localparam logic [31:0] ENABLE_WRITABLE    = 32'h03FF_FDFF;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_BUS_RESET           = 0;
  localparam int BIT_FRAME_START         = 1;
  localparam int BIT_PSEUDO_FRAME_START  = 2;
  localparam int BIT_SUSPEND             = 3;
  localparam int BIT_RESUME              = 4;
  localparam int BIT_SPEED_STATUS_CHANGE = 5;
  localparam int BIT_DMA_REASON_CHANGE   = 6;
  localparam int BIT_BUS_POWER_SENSE     = 7;
  localparam int BIT_SETUP_PACKET        = 8;
  localparam int BIT_RESERVED_9          = 9;
  localparam int BIT_CTRL_OUT            = 10;
  localparam int BIT_CTRL_IN             = 11;
  localparam int BIT_EP_RX_BASE          = 12;
  localparam int BIT_EP_TX_BASE          = 13;
  localparam int BIT_EP_TOP              = 25;

  // Receive bit of data endpoint ep (1 to 7)
  function automatic int ep_rx_bit(input int ep);
    return BIT_EP_RX_BASE + 2 * (ep - EP_FIRST);
  endfunction : ep_rx_bit

  // Transmit bit of data endpoint ep (1 to 7)
  function automatic int ep_tx_bit(input int ep);
    return BIT_EP_TX_BASE + 2 * (ep - EP_FIRST);
  endfunction : ep_tx_bit

endpackage : irq_enable_pkg

// file: irq_source_gate.sv
// Gates per-source event flags with the enable mask into one interrupt line
module irq_source_gate
  import irq_enable_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // Sources
  input  wire logic [REG_WIDTH-1:0] event_flags,
  input  wire logic [REG_WIDTH-1:0] enable_mask,
  // Results
  output logic      [REG_WIDTH-1:0] pending_q,
  output logic                      irq_q
);

  logic [REG_WIDTH-1:0] pending_d;
  logic                 irq_d;

  // Masking never touches the flag itself, only what reaches the line
  always_comb begin
    pending_d = event_flags & enable_mask & ENABLE_WRITABLE;
    irq_d     = |pending_d;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= ENABLE_RESET_VALUE;
      irq_q     <= 1'b0;
    end else begin
      pending_q <= pending_d;
      irq_q     <= irq_d;
    end
  end

endmodule : irq_source_gate

// file: tb_irq_enable_mask.sv
// Self-checking bench for the interrupt source enable mask
module tb_irq_enable_mask
  import irq_enable_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] WMASK = 32'h03FF_FDFF;
  logic sys_clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid, irq, v;
  logic [3:0] reg_wr_be;
  logic [31:0] reg_wr_data, reg_rd_data, irq_pending, ev, rv;
  logic [7:1] ep_rx_event, ep_tx_event;
  logic ctrl_in_event, ctrl_out_event, setup_packet_event, bus_power_sense_event,
    dma_reason_change_event, speed_status_change_event, resume_event, suspend_event,
    pseudo_frame_start_event, frame_start_event, bus_reset_event;
  logic ep7_tx_irq_en, ep7_rx_irq_en, ep6_tx_irq_en, ep6_rx_irq_en, ep5_tx_irq_en,
    ep5_rx_irq_en, ep4_tx_irq_en, ep4_rx_irq_en, ep3_tx_irq_en, ep3_rx_irq_en,
    ep2_tx_irq_en, ep2_rx_irq_en, ep1_tx_irq_en, ep1_rx_irq_en, ctrl_in_irq_en,
    ctrl_out_irq_en, setup_packet_irq_en, bus_power_sense_irq_en,
    dma_reason_change_irq_en, speed_status_change_irq_en, resume_irq_en,
    suspend_irq_en, pseudo_frame_start_irq_en, frame_start_irq_en, bus_reset_irq_en;
  logic [31:0] en_vec;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  irq_enable_mask i_irq_enable_mask (.*);
  host_mcu_model i_host_mcu_model (.*);
  for (genvar n = 1; n < 8; n++) begin : g_ep
    assign ep_rx_event[n] = ev[10+2*n];
    assign ep_tx_event[n] = ev[11+2*n];
  end
  assign {ctrl_in_event, ctrl_out_event} = ev[11:10];
  assign setup_packet_event = ev[8];
  assign {bus_power_sense_event, dma_reason_change_event, speed_status_change_event,
          resume_event, suspend_event, pseudo_frame_start_event, frame_start_event,
          bus_reset_event} = ev[7:0];
  // Individual enable outputs gathered back into register bit order
  assign en_vec = {6'h00, ep7_tx_irq_en, ep7_rx_irq_en, ep6_tx_irq_en, ep6_rx_irq_en,
                   ep5_tx_irq_en, ep5_rx_irq_en, ep4_tx_irq_en, ep4_rx_irq_en,
                   ep3_tx_irq_en, ep3_rx_irq_en, ep2_tx_irq_en, ep2_rx_irq_en,
                   ep1_tx_irq_en, ep1_rx_irq_en, ctrl_in_irq_en, ctrl_out_irq_en, 1'b0,
                   setup_packet_irq_en, bus_power_sense_irq_en, dma_reason_change_irq_en,
                   speed_status_change_irq_en, resume_irq_en, suspend_irq_en,
                   pseudo_frame_start_irq_en, frame_start_irq_en, bus_reset_irq_en};
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic t_reset();
    ev = 32'hFFFF_FFFF;
    i_host_mcu_model.rd(1'b0, 32'h0, v, rv);
    chk(32'(v), 32'h1);
    chk(rv, 32'h0);
    chk(irq_pending, 32'h0);
    ev = 32'h0;
    $display("reset values done");
  endtask : t_reset
  // One source enabled at a time: flags all up, then only its own flag down
  task automatic t_map();
    for (int b = 0; b < 32; b++) begin
      i_host_mcu_model.wr(4'hF, 32'h1 << b);
      chk(en_vec, WMASK & (32'h1 << b));
      ev = 32'hFFFF_FFFF;
      @(negedge sys_clk);
      chk(irq_pending, WMASK & (32'h1 << b));
      chk(32'(irq), 32'(WMASK[b]));
      ev = ~(32'h1 << b);
      @(negedge sys_clk);
      chk(irq_pending, 32'h0);
      i_host_mcu_model.rd(1'b0, 32'h0, v, rv);
      chk(rv, WMASK & (32'h1 << b));
    end
    ev = 32'h0;
    $display("bit map done");
  endtask : t_map
  task automatic t_bytes();
    i_host_mcu_model.wr(4'hF, 32'h0);
    i_host_mcu_model.wr(4'b0101, 32'hFFFF_FFFF);
    i_host_mcu_model.rd(1'b1, 32'h0, v, rv);
    chk(rv, 32'h00FF_00FF);
    i_host_mcu_model.rd(1'b0, 32'h0, v, rv);
    chk(rv, 32'h0);
    $display("byte lanes done");
  endtask : t_bytes
  task automatic t_lag();
    i_host_mcu_model.wr(4'hF, 32'h10);
    ev = 32'h10;
    @(negedge sys_clk);
    ev = 32'h0;
    chk(32'(irq), 32'h1);
    @(negedge sys_clk);
    chk(32'(irq), 32'h0);
    i_host_mcu_model.wr(4'hF, 32'hFFFF_FFFF);
    chk(en_vec, WMASK);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(en_vec, 32'h0);
    chk(irq_pending, 32'h0);
    i_host_mcu_model.rd(1'b0, 32'h0, v, rv);
    chk(32'(v), 32'h1);
    chk(rv, 32'h0);
    $display("lag and reset done");
  endtask : t_lag
  initial begin
    rst_n = 1'b0;
    ev = 32'h0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_map();
    t_bytes();
    t_lag();
    final_report();
  end
endmodule : tb_irq_enable_mask
